// >>> inc/lucc_pkg.sv
// Purpose: Shared constants and types for the line clock configuration block
// Assumes: 250 MHz system clock, 16 line channels in two banks of eight
// Notes:   Register offsets are byte addresses on the 8-bit host port
`default_nettype none

package lucc_pkg;

	localparam int unsigned CLK_HZ   = 250_000_000;
	localparam int unsigned CHANNELS = 16;
	localparam int unsigned BANK_CH  = 8;

	// Register map
	localparam logic [7:0] ADDR_RX_INV_LO    = 8'h13;
	localparam logic [7:0] ADDR_TX_INV_LO    = 8'h14;
	localparam logic [7:0] ADDR_CLOCK_CTRL   = 8'h15;
	localparam logic [7:0] ADDR_RX_OFF_LO    = 8'h16;
	localparam logic [7:0] ADDR_LOSS_STAT_LO = 8'h17;
	localparam logic [7:0] ADDR_IRQ_CTRL     = 8'h1E;
	localparam logic [7:0] ADDR_RX_INV_HI    = 8'h33;
	localparam logic [7:0] ADDR_TX_INV_HI    = 8'h34;
	localparam logic [7:0] ADDR_RX_OFF_HI    = 8'h36;
	localparam logic [7:0] ADDR_LOSS_STAT_HI = 8'h37;
	localparam logic [7:0] REG_RESET         = 8'h00;
	localparam logic [7:0] READ_UNMAPPED     = 8'h00;
	localparam logic [7:0] IRQ_CTRL_MASK     = 8'h03;
	localparam logic [7:0] CLEAR_ALL         = 8'hFF;

	// Clock control fields
	localparam int unsigned PLL_SRC_MSB = 7;
	localparam int unsigned PLL_SRC_LSB = 5;
	localparam int unsigned RATE_BIT    = 4;
	localparam int unsigned AUX_MSB     = 3;
	localparam int unsigned AUX_LSB     = 0;

	// Interrupt pin control fields
	localparam int unsigned IRQ_MODE_BIT = 1;
	localparam int unsigned CWE_BIT      = 0;

	// PLL bank codes
	localparam logic [1:0] BANK_LOW  = 2'b01;
	localparam logic [1:0] BANK_HIGH = 2'b10;

	// Auxiliary clock families, upper two bits of the select code
	localparam logic [1:0] AUX_GRP_E1  = 2'b00;
	localparam logic [1:0] AUX_GRP_T1  = 2'b01;
	localparam logic [1:0] AUX_GRP_SUB = 2'b10;

	// Frequencies in Hz
	localparam int unsigned REF_E1_HZ  = 2_048_000;
	localparam int unsigned REF_T1_HZ  = 1_544_000;
	localparam int unsigned AUX_SUB_HZ = 1_536_000;
	localparam int unsigned AUX_LOW_HZ = 32_000;

	// Substitution of the master clock after signal loss
	localparam int unsigned LOSS_SUBST_MS     = 10;
	localparam int unsigned LOSS_SUBST_CYCLES = LOSS_SUBST_MS * (CLK_HZ / 1000);
	localparam int unsigned SUBST_CNT_W       = 22;

	localparam int unsigned PHASE_W    = 32;
	localparam int unsigned MCLK_CNT_W = 8;

	typedef enum logic [1:0]
	{
		SEL_RAW    = 2'b00,
		SEL_MASTER = 2'b01,
		SEL_LOW    = 2'b11
	} lucc_src_type;

	// Phase step of a 32-bit accumulator at CLK_HZ for a given frequency
	function automatic logic [PHASE_W-1:0] lucc_phase_inc(input int unsigned hz);
		logic [63:0] wide;
		wide = (64'(hz) << PHASE_W) / 64'(CLK_HZ);
		return wide[PHASE_W-1:0];
	endfunction

endpackage

`default_nettype wire

// >>> hw/lucc_sync.sv
// Purpose: Two-flop synchroniser for a vector of independent levels
// Assumes: Each bit is a level; no multi-bit coherence is needed
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module lucc_sync
#(
	parameter int unsigned W = 1
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	always_comb
	begin
		meta_d = d;
		q_d    = meta_q;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			q      <= q_d;
		end
	end

endmodule

`default_nettype wire

// >>> hw/lucc_clock_switch.sv
// Purpose: Runt-free switch of one output clock between three sources
// Assumes: Source levels are already synchronised to clk
// Notes:   A stuck-high source is abandoned after LIMIT cycles
`timescale 1ns/1ps
`default_nettype none

module lucc_clock_switch
	import lucc_pkg::*;
#(
	parameter int unsigned LIMIT = LOSS_SUBST_CYCLES
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Sources
	input  var  lucc_src_type want,
	input  wire logic         raw_level,
	input  wire logic         master_level,
	// Result
	output logic              clk_out,
	output lucc_src_type      cur_sel
);

	localparam logic [SUBST_CNT_W-1:0] LIMIT_M1 = SUBST_CNT_W'(LIMIT - 1);

	lucc_src_type           cur_q;
	lucc_src_type           cur_d;
	logic [SUBST_CNT_W-1:0] wait_q;
	logic [SUBST_CNT_W-1:0] wait_d;
	logic                   forced_q;
	logic                   forced_d;
	logic                   out_d;
	logic                   cur_lvl;
	logic                   want_lvl;

	function automatic logic level_of(input lucc_src_type s, input logic r,
		input logic m);
		case (s)
			SEL_RAW:    return r;
			SEL_MASTER: return m;
			default:    return 1'b0;
		endcase
	endfunction

	// Change over while both clocks sit low, so no runt escapes, or force the change after LIMIT cycles of waiting
	always_comb
	begin
		cur_lvl  = level_of(cur_q, raw_level, master_level);
		want_lvl = level_of(want, raw_level, master_level);
		cur_d    = cur_q;
		wait_d   = '0;
		forced_d = 1'b0;
		if (want != cur_q)
		begin
			if (!cur_lvl && !want_lvl)
				cur_d = want;
			else if (wait_q >= LIMIT_M1)
			begin
				cur_d    = want;
				forced_d = 1'b1;
			end
			else
				wait_d = wait_q + 1'b1;
		end
		out_d = level_of(cur_d, raw_level, master_level);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cur_q    <= SEL_RAW;
			wait_q   <= '0;
			forced_q <= 1'b0;
			clk_out  <= 1'b0;
		end
		else
		begin
			cur_q    <= cur_d;
			wait_q   <= wait_d;
			forced_q <= forced_d;
			clk_out  <= out_d;
		end
	end

	assign cur_sel = cur_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	glitch_free_a: assert property ($changed(cur_q) && !forced_q |-> !clk_out)
		else $error("clock switched while output high");
	source_follow_a: assert property (
		cur_q == SEL_RAW && $past(cur_q) == SEL_RAW |-> clk_out == $past(raw_level))
		else $error("output does not follow its source");

endmodule

`default_nettype wire

// >>> hw/lucc_line_clock_config.sv
// Purpose: Clock configuration and interrupt pin control for 16 line channels
// Assumes: Host port is synchronous to clk; line pins are asynchronous
// Notes:   Output clocks are rebuilt at 250 MHz, so they carry 4 ns of jitter
//
// What this block does
// - Receive clock invert bit inverts the channel's recovered clock output while it follows the line clock, not the master or held-low substitute.
// - Transmit invert bit picks which transmit clock edge samples the rails.
// - Three-bit PLL source code picks channel one to eight of the chosen bank.
// - PLL source code acts only with bank code 01 (low) or 10 (high).
// - PLL uses the master clock while its channel reports signal loss.
// - Rate select one gives a 2.048 MHz reference, zero gives 1.544 MHz.
// - Four-bit auxiliary code picks family and multiple of the aux clock.
// - With loss-off bit set, a lost channel's recovered clock is held low.
// - With loss-off bit clear, a lost channel gets master clock within 10 ms.
// - Interrupt pin drives low when active; idle it floats or drives high.
// - With write-to-clear set, latched status clears only by writing one.
// - With write-to-clear clear, reading a latched status register clears it.
// - Bit k of each bank register serves that bank's channel k+1.
// - All registers of this block reset to zero.
`timescale 1ns/1ps
`default_nettype none

module lucc_line_clock_config
	import lucc_pkg::*;
#(
	parameter int unsigned SUBST_LIMIT_CYCLES = LOSS_SUBST_CYCLES
)
(
	// Clocks and reset
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire logic                  master_clock_in,
	// Host register port
	input  wire logic [7:0]            host_addr,
	input  wire logic [7:0]            host_wdata,
	input  wire logic                  host_wr_strobe,
	input  wire logic                  host_rd_strobe,
	output logic      [7:0]            host_rdata,
	// Receive side
	input  wire logic [CHANNELS-1:0]   rx_clock_raw,
	input  wire logic [2*CHANNELS-1:0] rx_rail_raw,
	input  wire logic [CHANNELS-1:0]   signal_loss,
	output logic      [CHANNELS-1:0]   recovered_rx_clock,
	output logic      [2*CHANNELS-1:0] rx_rail_outputs,
	// Transmit side
	input  wire logic [CHANNELS-1:0]   tx_line_clock,
	input  wire logic [2*CHANNELS-1:0] tx_rail_inputs,
	output logic      [2*CHANNELS-1:0] tx_rail_data,
	output logic      [CHANNELS-1:0]   tx_bit_strobe,
	// Reference clocks
	input  wire logic [1:0]            pll_bank_select,
	output logic                       pll_ref_clock,
	output logic                       rate_ref_clock,
	output logic                       aux_clock,
	// Interrupt pin
	input  wire logic                  irq_request,
	output logic                       irq_pin_out,
	output logic                       irq_pin_oe_n,
	output logic                       write_to_clear_enable
);

	localparam int unsigned SYNC_W = 5 * CHANNELS + 1;
	localparam logic [PHASE_W-1:0] INC_REF_E1 = lucc_phase_inc(REF_E1_HZ);
	localparam logic [PHASE_W-1:0] INC_REF_T1 = lucc_phase_inc(REF_T1_HZ);
	localparam logic [PHASE_W-1:0] INC_AUX_E1 = lucc_phase_inc(REF_E1_HZ);
	localparam logic [PHASE_W-1:0] INC_AUX_T1 = lucc_phase_inc(REF_T1_HZ);
	localparam logic [PHASE_W-1:0] INC_AUX_SB = lucc_phase_inc(AUX_SUB_HZ);
	localparam logic [PHASE_W-1:0] INC_AUX_LO = lucc_phase_inc(AUX_LOW_HZ);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
		return a == t;
	endfunction

	function automatic logic [PHASE_W-1:0] aux_inc(input logic [3:0] code);
		logic [PHASE_W-1:0] base;
		case (code[3:2])
			AUX_GRP_E1:  base = INC_AUX_E1;
			AUX_GRP_T1:  base = INC_AUX_T1;
			AUX_GRP_SUB: base = INC_AUX_SB;
			default:     base = INC_AUX_LO;
		endcase
		return base << code[1:0];
	endfunction

	// Link domain: the master clock only toggles a flag
	logic mtog_q;

	always_ff @(posedge master_clock_in or negedge reset_n)
	begin
		if (!reset_n)
			mtog_q <= 1'b0;
		else
			mtog_q <= ~mtog_q;
	end

	// Synchronised pins
	logic [SYNC_W-1:0]     sync_q;
	logic [CHANNELS-1:0]   rx_clk_s;
	logic [2*CHANNELS-1:0] rx_rail_s;
	logic [CHANNELS-1:0]   loss_s;
	logic [CHANNELS-1:0]   tx_line_clock_s;
	logic                  mtog_s;

	lucc_sync #(.W(SYNC_W)) u_sync
	(
		.clk     (clk),
		.reset_n (reset_n),
		.d       ({mtog_q, tx_line_clock_s_in(tx_line_clock), signal_loss, rx_rail_raw,
			rx_clock_raw}),
		.q       (sync_q)
	);

	function automatic logic [CHANNELS-1:0] tx_line_clock_s_in(
		input logic [CHANNELS-1:0] v);
		return v;
	endfunction

	assign rx_clk_s  = sync_q[CHANNELS-1:0];
	assign rx_rail_s = sync_q[3*CHANNELS-1:CHANNELS];
	assign loss_s    = sync_q[4*CHANNELS-1:3*CHANNELS];
	assign tx_line_clock_s    = sync_q[5*CHANNELS-1:4*CHANNELS];
	assign mtog_s    = sync_q[SYNC_W-1];

	// Transmit rails cross with their own pair of flops
	logic [2*CHANNELS-1:0] txr_s;

	lucc_sync #(.W(2 * CHANNELS)) u_sync_tx
	(
		.clk     (clk),
		.reset_n (reset_n),
		.d       (tx_rail_inputs),
		.q       (txr_s)
	);

	// Registers
	logic [CHANNELS-1:0] rx_inv_q, rx_inv_d;
	logic [CHANNELS-1:0] tx_inv_q, tx_inv_d;
	logic [CHANNELS-1:0] rx_off_q, rx_off_d;
	logic [CHANNELS-1:0] loss_lat_q, loss_lat_d;
	logic [CHANNELS-1:0] loss_prev_q, loss_rise, lat_clr;
	logic [7:0]          ccr_q, ccr_d, interrupt_pin_control_q, interrupt_pin_control_d, rdata_d;
	logic                irq_active, irq_out_d, irq_oe_n_d;

	always_comb
	begin
		rx_inv_d  = rx_inv_q;
		tx_inv_d  = tx_inv_q;
		rx_off_d  = rx_off_q;
		ccr_d     = ccr_q;
		interrupt_pin_control_d    = interrupt_pin_control_q;
		rdata_d   = host_rdata;
		lat_clr   = '0;
		loss_rise = loss_s & ~loss_prev_q;
		if (host_wr_strobe)
		begin
			case (host_addr)
				ADDR_RX_INV_LO:  rx_inv_d[BANK_CH-1:0]        = host_wdata;
				ADDR_RX_INV_HI:  rx_inv_d[CHANNELS-1:BANK_CH] = host_wdata;
				ADDR_TX_INV_LO:  tx_inv_d[BANK_CH-1:0]        = host_wdata;
				ADDR_TX_INV_HI:  tx_inv_d[CHANNELS-1:BANK_CH] = host_wdata;
				ADDR_RX_OFF_LO:  rx_off_d[BANK_CH-1:0]        = host_wdata;
				ADDR_RX_OFF_HI:  rx_off_d[CHANNELS-1:BANK_CH] = host_wdata;
				ADDR_CLOCK_CTRL: ccr_d  = host_wdata;
				ADDR_IRQ_CTRL:   interrupt_pin_control_d = host_wdata & IRQ_CTRL_MASK;
				default:         ;
			endcase
		end
		// Status policy: write-one-to-clear or clear-on-read
		if (interrupt_pin_control_q[CWE_BIT] && host_wr_strobe)
		begin
			if (hit(host_addr, ADDR_LOSS_STAT_LO))
				lat_clr[BANK_CH-1:0] = host_wdata;
			if (hit(host_addr, ADDR_LOSS_STAT_HI))
				lat_clr[CHANNELS-1:BANK_CH] = host_wdata;
		end
		else if (!interrupt_pin_control_q[CWE_BIT] && host_rd_strobe)
		begin
			if (hit(host_addr, ADDR_LOSS_STAT_LO))
				lat_clr[BANK_CH-1:0] = CLEAR_ALL;
			if (hit(host_addr, ADDR_LOSS_STAT_HI))
				lat_clr[CHANNELS-1:BANK_CH] = CLEAR_ALL;
		end
		// A new loss in the clearing cycle still latches
		loss_lat_d = (loss_lat_q & ~lat_clr) | loss_rise;
		if (host_rd_strobe)
		begin
			case (host_addr)
				ADDR_RX_INV_LO:    rdata_d = rx_inv_q[BANK_CH-1:0];
				ADDR_RX_INV_HI:    rdata_d = rx_inv_q[CHANNELS-1:BANK_CH];
				ADDR_TX_INV_LO:    rdata_d = tx_inv_q[BANK_CH-1:0];
				ADDR_TX_INV_HI:    rdata_d = tx_inv_q[CHANNELS-1:BANK_CH];
				ADDR_RX_OFF_LO:    rdata_d = rx_off_q[BANK_CH-1:0];
				ADDR_RX_OFF_HI:    rdata_d = rx_off_q[CHANNELS-1:BANK_CH];
				ADDR_CLOCK_CTRL:   rdata_d = ccr_q;
				ADDR_IRQ_CTRL:     rdata_d = interrupt_pin_control_q;
				ADDR_LOSS_STAT_LO: rdata_d = loss_lat_q[BANK_CH-1:0];
				ADDR_LOSS_STAT_HI: rdata_d = loss_lat_q[CHANNELS-1:BANK_CH];
				default:           rdata_d = READ_UNMAPPED;
			endcase
		end
		irq_active = irq_request | (|loss_lat_q);
		irq_out_d  = ~irq_active;
		irq_oe_n_d = ~(irq_active | interrupt_pin_control_q[IRQ_MODE_BIT]);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_inv_q     <= '0;
			tx_inv_q     <= '0;
			rx_off_q     <= '0;
			loss_lat_q   <= '0;
			loss_prev_q  <= '0;
			ccr_q        <= REG_RESET;
			interrupt_pin_control_q       <= REG_RESET;
			host_rdata   <= REG_RESET;
			irq_pin_out  <= 1'b1;
			irq_pin_oe_n <= 1'b1;
		end
		else
		begin
			rx_inv_q     <= rx_inv_d;
			tx_inv_q     <= tx_inv_d;
			rx_off_q     <= rx_off_d;
			loss_lat_q   <= loss_lat_d;
			loss_prev_q  <= loss_s;
			ccr_q        <= ccr_d;
			interrupt_pin_control_q       <= interrupt_pin_control_d;
			host_rdata   <= rdata_d;
			irq_pin_out  <= irq_out_d;
			irq_pin_oe_n <= irq_oe_n_d;
		end
	end

	assign write_to_clear_enable = interrupt_pin_control_q[CWE_BIT];

	// Rebuild the master clock: high for half of the last measured period
	logic                  mtog_prev_q, mlevel_q, mlevel_d, medge;
	logic [MCLK_CNT_W-1:0] mcnt_q, mcnt_d, mper_q, mper_d;

	always_comb
	begin
		medge    = mtog_s ^ mtog_prev_q;
		mcnt_d   = (&mcnt_q) ? mcnt_q : mcnt_q + 1'b1;
		mper_d   = mper_q;
		mlevel_d = mlevel_q;
		if (medge)
		begin
			mcnt_d   = '0;
			mper_d   = mcnt_q;
			mlevel_d = 1'b1;
		end
		else if (mcnt_q >= (mper_q >> 1))
			mlevel_d = 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mtog_prev_q <= 1'b0;
			mlevel_q    <= 1'b0;
			mcnt_q      <= '0;
			mper_q      <= '0;
		end
		else
		begin
			mtog_prev_q <= mtog_s;
			mlevel_q    <= mlevel_d;
			mcnt_q      <= mcnt_d;
			mper_q      <= mper_d;
		end
	end

	// Per-channel recovered clock source
	lucc_src_type ch_want [CHANNELS];
	lucc_src_type ch_cur  [CHANNELS];

	for (genvar k = 0; k < CHANNELS; k++)
	begin : g_ch
		assign ch_want[k] = !loss_s[k] ? SEL_RAW :
			(rx_off_q[k] ? SEL_LOW : SEL_MASTER);

		lucc_clock_switch #(.LIMIT(SUBST_LIMIT_CYCLES)) u_sw
		(
			.clk          (clk),
			.reset_n      (reset_n),
			.want         (ch_want[k]),
			.raw_level    (rx_clk_s[k] ^ rx_inv_q[k]),
			.master_level (mlevel_q),
			.clk_out      (recovered_rx_clock[k]),
			.cur_sel      (ch_cur[k])
		);
	end

	// PLL source; an unused bank code leaves the PLL on the master clock
	logic                pll_valid;
	logic [3:0]          pll_ch;
	lucc_src_type        pll_want;
	lucc_src_type        pll_cur;

	assign pll_valid = pll_bank_select == BANK_LOW ||
		pll_bank_select == BANK_HIGH;
	assign pll_ch    = {pll_bank_select == BANK_HIGH,
		ccr_q[PLL_SRC_MSB:PLL_SRC_LSB]};
	assign pll_want  = (pll_valid && !loss_s[pll_ch]) ? SEL_RAW : SEL_MASTER;

	lucc_clock_switch #(.LIMIT(SUBST_LIMIT_CYCLES)) u_pll_sw
	(
		.clk          (clk),
		.reset_n      (reset_n),
		.want         (pll_want),
		.raw_level    (rx_clk_s[pll_ch]),
		.master_level (mlevel_q),
		.clk_out      (pll_ref_clock),
		.cur_sel      (pll_cur)
	);

	// Rails and reference synthesis
	logic [CHANNELS-1:0]   tx_eff, tx_eff_prev_q, tx_rise;
	logic [2*CHANNELS-1:0] tx_data_d;
	logic [PHASE_W-1:0]    ref_acc_q, ref_acc_d, aux_acc_q, aux_acc_d;

	always_comb
	begin
		tx_eff    = tx_line_clock_s ^ tx_inv_q;
		tx_rise   = tx_eff & ~tx_eff_prev_q;
		tx_data_d = tx_rail_data;
		for (int k = 0; k < CHANNELS; k++)
		begin
			if (tx_rise[k])
				tx_data_d[2*k +: 2] = txr_s[2*k +: 2];
		end
		ref_acc_d = ref_acc_q + (ccr_q[RATE_BIT] ? INC_REF_E1 : INC_REF_T1);
		aux_acc_d = aux_acc_q + aux_inc(ccr_q[AUX_MSB:AUX_LSB]);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_eff_prev_q   <= '0;
			tx_rail_data    <= '0;
			tx_bit_strobe   <= '0;
			rx_rail_outputs <= '0;
			ref_acc_q       <= '0;
			aux_acc_q       <= '0;
		end
		else
		begin
			tx_eff_prev_q   <= tx_eff;
			tx_rail_data    <= tx_data_d;
			tx_bit_strobe   <= tx_rise;
			rx_rail_outputs <= rx_rail_s;
			ref_acc_q       <= ref_acc_d;
			aux_acc_q       <= aux_acc_d;
		end
	end

	assign rate_ref_clock = ref_acc_q[PHASE_W-1];
	assign aux_clock      = aux_acc_q[PHASE_W-1];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	rx_invert_a: assert property (ch_cur[0] == SEL_RAW && $past(ch_cur[0]) == SEL_RAW
		|-> recovered_rx_clock[0] == $past(rx_clk_s[0] ^ rx_inv_q[0]))
		else $error("recovered clock ignores invert bit");
	tx_edge_a: assert property (tx_bit_strobe[0]
		|-> $past(tx_line_clock_s[0] ^ tx_inv_q[0]) && !$past(tx_eff_prev_q[0]))
		else $error("transmit rails sampled on wrong edge");
	pll_bank_a: assert property ($fell(pll_valid)
		|-> ##[1:200] (pll_cur == SEL_MASTER || pll_valid))
		else $error("PLL left on a channel with unused bank code");
	pll_loss_a: assert property ($rose(loss_s[pll_ch]) && pll_valid
		|-> ##[1:200] (pll_cur == SEL_MASTER || !loss_s[pll_ch]))
		else $error("PLL did not fall back to master clock");
	loss_off_a: assert property (ch_cur[0] == SEL_LOW
		&& $past(ch_cur[0]) == SEL_LOW |-> !recovered_rx_clock[0])
		else $error("disabled recovered clock not held low");
	subst_a: assert property ($rose(loss_s[0]) && !rx_off_q[0]
		|-> ##[1:200] (ch_cur[0] == SEL_MASTER || !loss_s[0] || rx_off_q[0]))
		else $error("master clock not substituted");
	rate_sel_a: assert property (ccr_q[RATE_BIT] && $stable(ccr_q)
		|=> ref_acc_q - $past(ref_acc_q) == INC_REF_E1)
		else $error("reference rate step wrong");
	irq_drive_a: assert property (irq_active |=> !irq_pin_out && !irq_pin_oe_n)
		else $error("interrupt pin not driven low");
	irq_idle_a: assert property (!irq_active && !interrupt_pin_control_q[IRQ_MODE_BIT]
		|=> irq_pin_oe_n)
		else $error("idle interrupt pin not released");
	clear_read_a: assert property (host_rd_strobe && !interrupt_pin_control_q[CWE_BIT]
		&& hit(host_addr, ADDR_LOSS_STAT_LO)
		|=> loss_lat_q[BANK_CH-1:0] == $past(loss_rise[BANK_CH-1:0]))
		else $error("status not cleared on read");
	keep_read_a: assert property (host_rd_strobe && interrupt_pin_control_q[CWE_BIT]
		|=> (loss_lat_q & $past(loss_lat_q)) == $past(loss_lat_q))
		else $error("status changed by read in write-clear mode");

	loss_subst_c: cover property ($rose(loss_s[0]) && !rx_off_q[0]
		##[1:200] ch_cur[0] == SEL_MASTER);
	loss_off_c: cover property (ch_cur[0] == SEL_LOW);
	pll_high_c: cover property (pll_bank_select == BANK_HIGH && pll_cur == SEL_RAW);

endmodule

`default_nettype wire

// >>> testbench/lucc_frm_model.sv
// Purpose: Framer and line model for the clock configuration bench
// Assumes: Channel k runs its own fixed clock period
// Notes:   Periods differ per channel so edge counts tell channels apart
`timescale 1ns/1ps
`default_nettype none

module lucc_frm_model
(
	// Receive side
	output logic      [15:0] rx_clock_raw,
	output logic      [31:0] rx_rail_raw,
	// Transmit side
	output logic      [15:0] tx_line_clock,
	output logic      [31:0] tx_rail_inputs,
	input  wire logic [15:0] tx_inv
);
	for (genvar k = 0; k < 16; k++)
	begin : g_ch
		initial
		begin
			rx_clock_raw[k] = 1'b0;
			rx_rail_raw[2*k +: 2] = 2'h0;
			tx_line_clock[k] = 1'b0;
			tx_rail_inputs[2*k +: 2] = 2'h0;
		end
		always
		begin
			#(100 + 20 * k) rx_clock_raw[k] = ~rx_clock_raw[k];
			if (rx_clock_raw[k])
				rx_rail_raw[2*k +: 2] = rx_rail_raw[2*k +: 2] + 2'h1;
		end
		// Rails move on the edge opposite the sampling edge
		always
		begin
			#(120 + 20 * k) tx_line_clock[k] = ~tx_line_clock[k];
			if (tx_line_clock[k] === tx_inv[k])
				tx_rail_inputs[2*k +: 2] = tx_rail_inputs[2*k +: 2] + 2'h1;
		end
	end
endmodule

`default_nettype wire

// >>> testbench/lucc_line_clock_config_tb.sv
// Purpose: Self-checking bench for the line clock configuration block
// Assumes: Model supplies line clocks; bench drives the host port
// Notes:   Frequencies are judged by edge counts, so allow one edge slack
`timescale 1ns/1ps
`default_nettype none

module lucc_line_clock_config_tb;
	logic        clk, reset_n, master_clock_in;
	logic [7:0]  host_addr, host_wdata, host_rdata;
	logic        host_wr_strobe, host_rd_strobe;
	logic [15:0] rx_clock_raw, signal_loss, recovered_rx_clock;
	logic [15:0] tx_line_clock, tx_bit_strobe, tx_inv;
	logic [31:0] rx_rail_raw, rx_rail_outputs, tx_rail_inputs, tx_rail_data;
	logic [1:0]  pll_bank_select;
	logic        pll_ref_clock, rate_ref_clock, aux_clock, irq_request;
	logic        irq_pin_out, irq_pin_oe_n, write_to_clear_enable;
	wire         irq_pin = irq_pin_oe_n ? 1'bz : irq_pin_out;
	int          err_count, num_checks, c [4];

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		master_clock_in = 1'b0;
		#1.3;
		// Not the 2.048 MHz that suits low aux jitter; jitter is not judged here
		forever #62.5 master_clock_in = ~master_clock_in;
	end

	lucc_line_clock_config #(.SUBST_LIMIT_CYCLES(64)) u_dut
	(
		.clk, .reset_n, .master_clock_in, .host_addr, .host_wdata,
		.host_wr_strobe, .host_rd_strobe, .host_rdata, .rx_clock_raw,
		.rx_rail_raw, .signal_loss, .recovered_rx_clock, .rx_rail_outputs,
		.tx_line_clock, .tx_rail_inputs, .tx_rail_data, .tx_bit_strobe,
		.pll_bank_select, .pll_ref_clock, .rate_ref_clock, .aux_clock,
		.irq_request, .irq_pin_out, .irq_pin_oe_n, .write_to_clear_enable
	);
	lucc_frm_model u_frm
	(
		.rx_clock_raw, .rx_rail_raw, .tx_line_clock, .tx_rail_inputs, .tx_inv
	);

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic near(input int g, input real e);
		num_checks++;
		if (g < e - 1.5 || g > e + 1.5)
		begin
			err_count++;
			$display("Error %0t: count %0d exp %0f", $time, g, e);
		end
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		host_addr <= a;
		host_wdata <= d;
		host_wr_strobe <= 1'b1;
		@(posedge clk);
		host_wr_strobe <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		host_addr <= a;
		host_rd_strobe <= 1'b1;
		@(posedge clk);
		host_rd_strobe <= 1'b0;
		@(negedge clk);
		chk(host_rdata, e);
	endtask
	// Counts rising edges of pll, rate, aux and channel 1 clocks
	task automatic edges(input int n);
		logic [3:0] p, v;
		c = '{0, 0, 0, 0};
		p = 4'h0;
		repeat (n)
		begin
			@(negedge clk);
			v = {recovered_rx_clock[0], aux_clock, rate_ref_clock, pll_ref_clock};
			for (int i = 0; i < 4; i++)
				c[i] += int'(v[i] && !p[i]);
			p = v;
		end
	endtask
	function automatic real rx_edges(input int k);
		return 8000.0 / (200.0 + 40.0 * k);
	endfunction

	task automatic t_regs();
		logic [7:0] a [8];
		a = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h1E, 8'h33, 8'h34, 8'h36};
		foreach (a[i])
			rdc(a[i], 8'h00);
		wr(8'h40, 8'hFF);
		rdc(8'h40, 8'h00);
		foreach (a[i])
			wr(a[i], 8'hA5 + 8'(i));
		foreach (a[i])
			rdc(a[i], a[i] == 8'h1E ? 8'h01 : 8'hA5 + 8'(i));
		foreach (a[i])
			wr(a[i], 8'h00);
	endtask
	task automatic t_irq();
		@(posedge clk);
		irq_request <= 1'b1;
		hold(4);
		chk({7'h0, irq_pin}, 8'h00);
		@(posedge clk);
		irq_request <= 1'b0;
		hold(4);
		chk({7'h0, irq_pin}, {7'h0, 1'bz});
		wr(8'h1E, 8'h02);
		hold(4);
		chk({7'h0, irq_pin}, 8'h01);
		wr(8'h1E, 8'h00);
	endtask
	// Channel 10 lives in bit 1 of the high status byte
	task automatic t_latch();
		@(posedge clk);
		signal_loss[9] <= 1'b1;
		hold(8);
		rdc(8'h37, 8'h02);
		rdc(8'h37, 8'h00);
		wr(8'h1E, 8'h01);
		signal_loss[9] <= 1'b0;
		hold(8);
		@(posedge clk);
		signal_loss[9] <= 1'b1;
		hold(8);
		chk({7'h0, write_to_clear_enable}, 8'h01);
		rdc(8'h37, 8'h02);
		rdc(8'h37, 8'h02);
		wr(8'h37, 8'h02);
		rdc(8'h37, 8'h00);
		wr(8'h1E, 8'h00);
		signal_loss[9] <= 1'b0;
	endtask
	task automatic t_rxinv(input int ch, input logic inv);
		logic [1:0] p;
		wr(ch < 8 ? 8'h13 : 8'h33, 8'(inv) << (ch % 8));
		hold(10);
		p = rx_rail_outputs[2*ch +: 2];
		repeat (1200)
		begin
			@(negedge clk);
			if (rx_rail_outputs[2*ch +: 2] !== p)
			begin
				chk({7'h0, recovered_rx_clock[ch]}, {7'h0, !inv});
				chk({6'h0, rx_rail_outputs[2*ch +: 2]},
					{6'h0, rx_rail_raw[2*ch +: 2]});
			end
			p = rx_rail_outputs[2*ch +: 2];
		end
	endtask
	task automatic t_txinv(input int ch, input logic inv);
		wr(ch < 8 ? 8'h14 : 8'h34, 8'(inv) << (ch % 8));
		tx_inv[ch] <= inv;
		hold(10);
		repeat (1500)
		begin
			@(negedge clk);
			if (tx_bit_strobe[ch] === 1'b1)
			begin
				chk({6'h0, tx_rail_data[2*ch +: 2]},
					{6'h0, tx_rail_inputs[2*ch +: 2]});
				chk({7'h0, tx_line_clock[ch] ^ inv}, 8'h01);
			end
		end
	endtask
	task automatic t_pll(input logic [1:0] b, input int code, input real e);
		@(posedge clk);
		pll_bank_select <= b;
		wr(8'h15, 8'(code) << 5);
		hold(200);
		edges(2000);
		near(c[0], e);
	endtask
	task automatic t_loss();
		@(posedge clk);
		signal_loss[0] <= 1'b1;
		hold(200);
		rdc(8'h17, 8'h01);
		edges(2000);
		near(c[0], 64.0);
		near(c[3], 64.0);
		wr(8'h16, 8'h01);
		hold(200);
		edges(2000);
		near(c[3], 0.0);
		chk({7'h0, recovered_rx_clock[0]}, 8'h00);
		@(posedge clk);
		signal_loss[0] <= 1'b0;
		hold(200);
		edges(2000);
		near(c[0], rx_edges(0));
		near(c[3], rx_edges(0));
		wr(8'h16, 8'h00);
	endtask
	// Window of 2500 cycles is 10 us, so Hz times 1e-5 gives edges
	task automatic t_clocks();
		real b [4];
		b = '{2.048e6, 1.544e6, 1.536e6, 32.0e3};
		for (int i = 0; i < 16; i++)
		begin
			wr(8'h15, {3'h0, i[0], i[3:0]});
			hold(20);
			edges(2500);
			near(c[2], b[i / 4] * (1 << (i % 4)) * 1.0e-5);
			near(c[1], (i[0] ? 2.048e6 : 1.544e6) * 1.0e-5);
		end
		wr(8'h15, 8'h00);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		reset_n = 1'b0;
		host_addr = 8'h00;
		host_wdata = 8'h00;
		host_wr_strobe = 1'b0;
		host_rd_strobe = 1'b0;
		signal_loss = 16'h0000;
		tx_inv = 16'h0000;
		pll_bank_select = 2'b01;
		irq_request = 1'b0;
		err_count = 0;
		num_checks = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_irq();
		t_latch();
		t_rxinv(0, 1'b1);
		t_rxinv(0, 1'b0);
		t_rxinv(8, 1'b1);
		t_rxinv(8, 1'b0);
		t_txinv(0, 1'b0);
		t_txinv(0, 1'b1);
		t_txinv(9, 1'b1);
		t_txinv(9, 1'b0);
		for (int k = 0; k < 8; k++)
			t_pll(2'b01, k, rx_edges(k));
		t_pll(2'b10, 0, rx_edges(8));
		t_pll(2'b10, 7, rx_edges(15));
		t_pll(2'b00, 7, 64.0);
		t_pll(2'b11, 7, 64.0);
		t_pll(2'b01, 0, rx_edges(0));
		t_loss();
		t_clocks();
		summarize();
	end
endmodule

`default_nettype wire
